//--- src/gdp_pkg.sv
// Package: register map, field layout and timing of the driver settings
package gdp_pkg;
   // Register bus width
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   // Register offsets
   localparam logic [7:0] OFS_FIRST = 8'hAC;
   localparam logic [7:0] OFS_SECOND = 8'hAE;
   localparam logic [7:0] OFS_STATUS = 8'hB0;
   localparam logic [7:0] OFS_MASK = 8'hB1;
   localparam logic [7:0] OFS_CTRL = 8'hB2;
   localparam logic [7:0] OFS_STATE = 8'hB3;
   // Reset values
   localparam logic [31:0] RST_FIRST = 32'h10228100;
   localparam logic [31:0] RST_SECOND = 32'h01200000;
   localparam logic [3:0] RST_MASK = 4'h0;
   // Field positions in the first settings register
   localparam int SLEW_LO = 26;
   localparam int OV_SEL_BIT = 19;
   localparam int OV_ON_BIT = 18;
   localparam int HOT_REP_BIT = 16;
   localparam int RETRY_BIT = 11;
   localparam int OC_LVL_BIT = 10;
   localparam int OC_MODE_LO = 8;
   localparam int GAIN_LO = 0;
   // Control register bits
   localparam int CTRL_AUTO_GAIN = 0;
   localparam int CTRL_CLR_LATCH = 1;
   // Status bits
   localparam int NUM_EV = 4;
   localparam int EV_OC = 0;
   localparam int EV_OV = 1;
   localparam int EV_HOT = 2;
   localparam int EV_RETRY = 3;
   // Overcurrent responses
   localparam logic [1:0] OC_LATCH = 2'h0;
   localparam logic [1:0] OC_RETRY = 2'h1;
   localparam logic [1:0] OC_REPORT = 2'h2;
   localparam logic [1:0] OC_IGNORE = 2'h3;
   // Times and clock rate
   localparam longint CLK_HZ = 50000000;
   localparam longint RETRY_SHORT_MS = 5;
   localparam longint RETRY_LONG_MS = 500;
   localparam longint GAIN_TUNE_MS = 1;
   localparam longint SHORT_CYC = CLK_HZ / 1000 * RETRY_SHORT_MS;
   localparam longint LONG_CYC = CLK_HZ / 1000 * RETRY_LONG_MS;
   localparam longint TUNE_CYC = CLK_HZ / 1000 * GAIN_TUNE_MS;
   // Analog comparator flags from the power stage
   typedef struct packed {
      logic hot_warning;
      logic above_24a;
      logic above_16a;
      logic supply_above_32v;
      logic supply_above_20v;
   } gdp_sense_t;
   // Settings handed to the analog stage
   typedef struct packed {
      logic [1:0] slew_sel;
      logic [1:0] sense_gain;
      logic oc_level_24a;
   } gdp_analog_t;
endpackage

//--- src/gdp_sync.sv
// Two-stage synchroniser for asynchronous inputs
`timescale 1ns/1ps
module gdp_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   // First stage, read only by second stage
   logic [W-1:0] meta_q;

   // Both stages clear on reset
   always_ff @(posedge clk) begin
      if (!rstn) begin
         meta_q <= '0;
         dout <= '0;
      end else begin
         meta_q <= din;
         dout <= meta_q;
      end
   end
endmodule

//--- src/gdp_timer.sv
// Down counter giving a one-cycle pulse when a started interval ends
`timescale 1ns/1ps
module gdp_timer #(
   parameter int W = 25
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic start,
   input wire logic [W-1:0] cycles,
   output logic busy,
   output logic done
);
   // Remaining cycles
   logic [W-1:0] cnt_q;

   // Start reloads, else count to zero
   always_ff @(posedge clk) begin
      if (!rstn) begin
         cnt_q <= '0;
         busy <= 1'b0;
         done <= 1'b0;
      end else if (start) begin
         cnt_q <= cycles;
         busy <= 1'b1;
         done <= 1'b0;
      end else begin
         done <= busy && (cnt_q <= W'(1));
         busy <= busy && (cnt_q > W'(1));
         cnt_q <= busy ? cnt_q - W'(1) : cnt_q;
      end
   end
endmodule

//--- src/gdp_top.sv
// Gate driver and protection settings with fault handling
//
// Summary of operation
// R1 - Slew field picks 25/50/125/200 V/us
// R2 - Threshold bit: clear 32 V, set 20 V
// R3 - Overvoltage enable bit, reset off
// R4 - Hot warning drives fault pin when enabled
// R5 - Retry bit: clear 5 ms, set 500 ms
// R6 - Trip level bit: clear 16 A, set 24 A
// R7 - Response 0: latched fault until cleared
// R8 - Response 1 (reset): fault auto-retries
// R9 - Response 2: report only, outputs run
// R10 - Response 3: no report, no action
// R11 - Fixed gain code used without auto gain
// R12 - Auto gain retunes every millisecond
// R13 - Threshold inert while protection disabled
`timescale 1ns/1ps
module gdp_top #(
   parameter longint RETRY_SHORT = gdp_pkg::SHORT_CYC,
   parameter longint RETRY_LONG = gdp_pkg::LONG_CYC,
   parameter longint TUNE_PERIOD = gdp_pkg::TUNE_CYC
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [gdp_pkg::ADDR_W-1:0] addr,
   input wire logic [gdp_pkg::DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [gdp_pkg::DATA_W-1:0] rdata,
   input wire gdp_pkg::gdp_sense_t sense,
   input wire logic [1:0] current_range,
   output gdp_pkg::gdp_analog_t analog,
   output logic bridge_off,
   output logic overvolt_trip,
   output logic fault_pin_n,
   output logic irq
);
   localparam int TW = 25;

   // Stored settings, full words since reserved bits are R/W
   logic [31:0] first_q;
   logic [31:0] second_q;
   // Interrupt status and mask
   logic [3:0] status_q;
   logic [3:0] mask_q;
   // Own control bit for automatic gain
   logic auto_gain_q;
   // Registered read data
   logic [31:0] rdata_q;

   // Synchronised comparator flags and range code
   gdp_pkg::gdp_sense_t sense_s;
   logic [1:0] range_s;

   // Address decode
   wire hit_first = addr == gdp_pkg::OFS_FIRST;
   wire hit_second = addr == gdp_pkg::OFS_SECOND;
   wire hit_status = addr == gdp_pkg::OFS_STATUS;
   wire hit_mask = addr == gdp_pkg::OFS_MASK;
   wire hit_ctrl = addr == gdp_pkg::OFS_CTRL;
   wire hit_state = addr == gdp_pkg::OFS_STATE;
   wire wr_first = wr && hit_first;
   wire wr_second = wr && hit_second;
   wire wr_mask = wr && hit_mask;
   wire wr_ctrl = wr && hit_ctrl;
   wire rd_status = rd && hit_status;

   // Field views of the first register
   wire [1:0] slew_rate = first_q[gdp_pkg::SLEW_LO +: 2];
   wire supply_overvolt_threshold_sel = first_q[gdp_pkg::OV_SEL_BIT];
   wire supply_overvolt_protect_on = first_q[gdp_pkg::OV_ON_BIT];
   wire hot_warning_report_on = first_q[gdp_pkg::HOT_REP_BIT];
   wire overcurrent_retry_interval = first_q[gdp_pkg::RETRY_BIT];
   wire overcurrent_trip_level = first_q[gdp_pkg::OC_LVL_BIT];
   wire [1:0] overcurrent_response = first_q[gdp_pkg::OC_MODE_LO +: 2];
   wire [1:0] sense_amp_fixed_gain = first_q[gdp_pkg::GAIN_LO +: 2];

   // Latch clear strobe, write one to clear
   wire clr_latch = wr_ctrl && wdata[gdp_pkg::CTRL_CLR_LATCH];

   // Bring the analog flags into the clock domain
   gdp_sync #(
      .W(5)
   ) u_sense_sync (
      .clk(clk),
      .rstn(rstn),
      .din(sense),
      .dout(sense_s)
   );

   // Range code is slow, a plain two-stage pass is enough
   gdp_sync #(
      .W(2)
   ) u_range_sync (
      .clk(clk),
      .rstn(rstn),
      .din(current_range),
      .dout(range_s)
   );

   // R6 trip threshold select
   wire oc_level = overcurrent_trip_level ? sense_s.above_24a
                                          : sense_s.above_16a;
   // Previous trip level for edge detection
   logic oc_prev_q;
   wire oc_rise = oc_level && !oc_prev_q;

   // R10 code 3 takes no notice of the event
   wire oc_seen = oc_rise && (overcurrent_response != gdp_pkg::OC_IGNORE);

   // R2 level picks 20 V when set, 32 V when clear
   wire ov_level = supply_overvolt_threshold_sel ? sense_s.supply_above_20v
                                                 : sense_s.supply_above_32v;
   // R13 no protective effect while disabled
   wire ov_active = supply_overvolt_protect_on && ov_level;
   // Previous overvoltage state
   logic ov_prev_q;

   // R4 hot warning gated by report enable
   wire hot_report = hot_warning_report_on && sense_s.hot_warning;
   // Previous hot warning report
   logic hot_prev_q;

   // Overcurrent fault held, latched or waiting for retry
   logic oc_hold_q;
   // Fault reported with outputs running
   logic oc_report_q;
   // Whether the held fault is the retrying kind
   logic oc_auto_q;

   // Retry interval choice
   logic [TW-1:0] retry_cycles;
   // R5 5 ms when clear, 500 ms when set
   assign retry_cycles = overcurrent_retry_interval ? TW'(RETRY_LONG)
                                                    : TW'(RETRY_SHORT);

   // Retry timer starts on an auto-retry trip
   wire retry_start = oc_rise &&
                      (overcurrent_response == gdp_pkg::OC_RETRY);
   logic retry_busy;
   logic retry_done;

   gdp_timer #(
      .W(TW)
   ) u_retry (
      .clk(clk),
      .rstn(rstn),
      .start(retry_start),
      .cycles(retry_cycles),
      .busy(retry_busy),
      .done(retry_done)
   );

   // Edge history of the watched levels
   always_ff @(posedge clk) begin
      if (!rstn) begin
         oc_prev_q <= 1'b0;
         ov_prev_q <= 1'b0;
         hot_prev_q <= 1'b0;
      end else begin
         oc_prev_q <= oc_level;
         ov_prev_q <= ov_active;
         hot_prev_q <= hot_report;
      end
   end

   // Held overcurrent fault; a new trip wins over a clear
   always_ff @(posedge clk) begin
      if (!rstn) begin
         oc_hold_q <= 1'b0;
         oc_auto_q <= 1'b0;
      end else if (oc_rise) begin
         case (overcurrent_response)
            // R7 latched fault until cleared
            gdp_pkg::OC_LATCH: begin
               oc_hold_q <= 1'b1;
               oc_auto_q <= 1'b0;
            end
            // R8 fault that clears itself
            gdp_pkg::OC_RETRY: begin
               oc_hold_q <= 1'b1;
               oc_auto_q <= 1'b1;
            end
            // Report only or ignore: no hold
            default: begin
               oc_hold_q <= oc_hold_q;
               oc_auto_q <= oc_auto_q;
            end
         endcase
      end else if (oc_auto_q && retry_done) begin
         // R8 release when the retry time runs out
         oc_hold_q <= 1'b0;
         oc_auto_q <= 1'b0;
      end else if (!oc_auto_q && clr_latch) begin
         // R7 software clear of the latched fault
         oc_hold_q <= 1'b0;
      end
   end

   // Report-only fault shown while the overcurrent lasts
   always_ff @(posedge clk) begin
      if (!rstn) begin
         oc_report_q <= 1'b0;
      end else begin
         // R9 report without protective action
         oc_report_q <= oc_level &&
                        (overcurrent_response == gdp_pkg::OC_REPORT);
      end
   end

   // Automatic gain tuning tick
   logic [TW-1:0] tune_cnt_q;
   wire tune_tick = tune_cnt_q == '0;
   // Gain chosen by the automatic loop
   logic [1:0] auto_gain_val_q;

   // R12 retune once per millisecond while enabled
   always_ff @(posedge clk) begin
      if (!rstn) begin
         tune_cnt_q <= TW'(TUNE_PERIOD - 1);
         auto_gain_val_q <= 2'h0;
      end else if (!auto_gain_q) begin
         tune_cnt_q <= TW'(TUNE_PERIOD - 1);
         auto_gain_val_q <= auto_gain_val_q;
      end else if (tune_tick) begin
         tune_cnt_q <= TW'(TUNE_PERIOD - 1);
         // Small currents get the high gain
         auto_gain_val_q <= ~range_s;
      end else begin
         tune_cnt_q <= tune_cnt_q - TW'(1);
      end
   end

   // R11 fixed gain only while automatic gain is off
   wire [1:0] gain_now = auto_gain_q ? auto_gain_val_q
                                     : sense_amp_fixed_gain;

   // Events for the sticky status bits
   logic [3:0] ev;
   assign ev[gdp_pkg::EV_OC] = oc_seen;
   assign ev[gdp_pkg::EV_OV] = ov_active && !ov_prev_q;
   assign ev[gdp_pkg::EV_HOT] = hot_report && !hot_prev_q;
   assign ev[gdp_pkg::EV_RETRY] = oc_auto_q && retry_done;

   // Sticky status, read clears, new event wins
   always_ff @(posedge clk) begin
      if (!rstn) begin
         status_q <= '0;
      end else if (rd_status) begin
         status_q <= ev;
      end else begin
         status_q <= status_q | ev;
      end
   end

   // Settings registers, written whole
   always_ff @(posedge clk) begin
      if (!rstn) begin
         // R3 protection off after reset
         first_q <= gdp_pkg::RST_FIRST;
         second_q <= gdp_pkg::RST_SECOND;
      end else begin
         if (wr_first) begin
            first_q <= wdata;
         end
         if (wr_second) begin
            second_q <= wdata;
         end
      end
   end

   // Mask and control
   always_ff @(posedge clk) begin
      if (!rstn) begin
         mask_q <= gdp_pkg::RST_MASK;
         auto_gain_q <= 1'b0;
      end else begin
         if (wr_mask) begin
            mask_q <= wdata[3:0];
         end
         if (wr_ctrl) begin
            auto_gain_q <= wdata[gdp_pkg::CTRL_AUTO_GAIN];
         end
      end
   end

   // Live state word for software
   wire [31:0] state_word = {24'h0, retry_busy, gain_now,
                             hot_report, ov_active, oc_report_q,
                             oc_auto_q, oc_hold_q};

   // Read mux; unmapped addresses read zero
   logic [31:0] rd_mux;
   assign rd_mux = hit_first ? first_q :
                   hit_second ? second_q :
                   hit_status ? {28'h0, status_q} :
                   hit_mask ? {28'h0, mask_q} :
                   hit_ctrl ? {31'h0, auto_gain_q} :
                   hit_state ? state_word : 32'h0;

   // Read data stands for the one cycle after the strobe
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rd ? rd_mux : 32'h0;
      end
   end
   assign rdata = rdata_q;

   // Registered outputs to the power stage and the fault pin
   always_ff @(posedge clk) begin
      if (!rstn) begin
         analog <= '0;
         bridge_off <= 1'b0;
         overvolt_trip <= 1'b0;
         fault_pin_n <= 1'b1;
         irq <= 1'b0;
      end else begin
         // R1 slew code to the driver
         analog.slew_sel <= slew_rate;
         analog.sense_gain <= gain_now;
         analog.oc_level_24a <= overcurrent_trip_level;
         // R7 held fault stops the bridge
         bridge_off <= oc_hold_q || ov_active;
         overvolt_trip <= ov_active;
         // R4 fault pin collects reported faults
         fault_pin_n <= !(oc_hold_q || oc_report_q ||
                          ov_active || hot_report);
         irq <= |(status_q & mask_q);
      end
   end
endmodule

//--- testbench/gdp_top_sva.sv
// Port checker for the driver settings block
`timescale 1ns/1ps
module gdp_top_sva #(
   parameter longint RETRY_SHORT = 20,
   parameter longint RETRY_LONG = 40
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [gdp_pkg::ADDR_W-1:0] addr,
   input wire logic [gdp_pkg::DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [gdp_pkg::DATA_W-1:0] rdata,
   input wire gdp_pkg::gdp_analog_t analog,
   input wire logic bridge_off,
   input wire logic overvolt_trip,
   input wire logic irq
);
   logic [31:0] cfg_q; // Shadow of first settings word
   logic [3:0] mask_q; // Shadow of the mask
   logic auto_q; // Shadow of auto gain
   logic [31:0] hi_q; // Cycles with the bridge off
   logic mapped; // Address hits a register
   longint lim; // Expected retry span
   assign mapped = addr inside {8'hAC, 8'hAE, 8'hB0, 8'hB1, 8'hB2, 8'hB3};
   assign lim = cfg_q[11] ? RETRY_LONG : RETRY_SHORT;
   // Shadows move on the same edge as the design's registers
   always_ff @(posedge clk) begin
      if (!rstn) begin
         cfg_q <= gdp_pkg::RST_FIRST;
         mask_q <= gdp_pkg::RST_MASK;
         auto_q <= 1'b0;
      end else if (wr && addr == gdp_pkg::OFS_FIRST) begin
         cfg_q <= wdata;
      end else if (wr && addr == gdp_pkg::OFS_MASK) begin
         mask_q <= wdata[3:0];
      end else if (wr && addr == gdp_pkg::OFS_CTRL) begin
         auto_q <= wdata[0];
      end
   end
   // Off-time counter, cleared whenever the bridge runs
   always_ff @(posedge clk) begin
      if (!rstn || !bridge_off) begin
         hi_q <= 32'h0;
      end else begin
         hi_q <= hi_q + 32'h1;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // Bridge back on with no overvoltage in the last two cycles
   sequence retry_end;
      $fell(bridge_off) && !$past(overvolt_trip) &&
         !$past(overvolt_trip, 2) && cfg_q[9:8] == 2'h1;
   endsequence
   // Protection held off for three cycles
   sequence ov_off3;
      !cfg_q[18] [*3];
   endsequence
   chk_rd_quiet: assert property (!$past(rd) |-> rdata == 32'h0)
      else $error("read data outside its slot");
   chk_rd_unmap: assert property (rd && !mapped |=> rdata == 32'h0)
      else $error("unmapped read gave data");
   chk_rd_first: assert property (
      rd && addr == gdp_pkg::OFS_FIRST |=> rdata == $past(cfg_q))
      else $error("first settings read wrong");
   chk_slew_map: assert property (
      analog.slew_sel == $past(cfg_q[27:26]))
      else $error("slew select differs from field");
   chk_level_map: assert property (
      analog.oc_level_24a == $past(cfg_q[10]))
      else $error("trip level differs from field");
   chk_gain_fixed: assert property (
      !$past(auto_q) |-> analog.sense_gain == $past(cfg_q[1:0]))
      else $error("fixed gain not applied");
   chk_ov_off: assert property (ov_off3 |-> !overvolt_trip)
      else $error("overvoltage trip while disabled");
   chk_irq_mask: assert property ((mask_q == 4'h0) [*2] |-> !irq)
      else $error("interrupt with all masked");
   chk_retry_span: assert property (
      retry_end |-> hi_q >= lim - 1 && hi_q <= lim + 1)
      else $error("retry interval length wrong");
endmodule

bind gdp_top gdp_top_sva #(
   .RETRY_SHORT(RETRY_SHORT),
   .RETRY_LONG(RETRY_LONG)
) u_gdp_top_sva (
   .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
   .rd(rd), .rdata(rdata), .analog(analog), .bridge_off(bridge_off),
   .overvolt_trip(overvolt_trip), .irq(irq)
);

//--- testbench/gdp_top_tb_top.sv
// Self-checking bench for the driver settings block
`timescale 1ns/1ps
module gdp_top_tb_top;
   localparam longint RS = 20; // Shortened retry spans
   localparam longint RL = 40;
   localparam logic [7:0] FR = gdp_pkg::OFS_FIRST;
   localparam logic [7:0] ST = gdp_pkg::OFS_STATUS;
   localparam logic [7:0] CT = gdp_pkg::OFS_CTRL;
   localparam logic [7:0] MK = gdp_pkg::OFS_MASK;
   logic clk;
   logic rstn = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   gdp_pkg::gdp_sense_t sense = '0;
   logic [1:0] current_range = 2'h0;
   gdp_pkg::gdp_analog_t analog;
   logic bridge_off, overvolt_trip, fault_pin_n, irq;
   logic rd_d = 1'b0; // Marks the read data slot
   logic [31:0] expq[$]; // Expected read data, oldest first
   logic [31:0] seed = 32'h419D3310;
   logic [31:0] b; // Base settings word
   logic [31:0] v;
   int n_mismatch = 0;
   int checked = 0;
   int n;
   gdp_top #(.RETRY_SHORT(RS), .RETRY_LONG(RL), .TUNE_PERIOD(64'd8))
   u_gdp_top (
      .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .sense(sense), .current_range(current_range),
      .analog(analog), .bridge_off(bridge_off),
      .overvolt_trip(overvolt_trip), .fault_pin_n(fault_pin_n), .irq(irq)
   );
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Pin picker: 0 bridge, 1 overvoltage, 2 fault pin, 3 interrupt
   function automatic logic pin(input int id);
      case (id)
         0: return bridge_off;
         1: return overvolt_trip;
         2: return fault_pin_n;
         default: return irq;
      endcase
   endfunction
   task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_bit(input int id, input logic exp);
      checked++;
      if (pin(id) !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %0t pin %0d expected %b", $time, id, exp);
      end
   endtask
   // Fault path settles within four cycles; eight is margin
   task automatic see(input int id, input logic exp);
      repeat (8) @(negedge clk);
      cmp_bit(id, exp);
   endtask
   task automatic put(input logic [4:0] s);
      @(posedge clk);
      sense <= s;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Note the expectation, then issue a one-cycle read
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      expq.push_back(e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
   endtask
   // Trip, drop the level, then count the remaining off cycles
   task automatic retry_len(input logic [31:0] cfg, input longint span);
      wr_reg(FR, cfg);
      put(5'h04);
      for (n = 0; n < 10 && bridge_off !== 1'b1; n++) @(negedge clk);
      put(5'h00);
      for (n = 0; n < 60 && bridge_off === 1'b1; n++) @(negedge clk);
      // Off for the whole span plus the cycle that releases the hold
      cmp32(32'(n), 32'(span + 1));
   endtask
   task automatic tally_and_finish();
      $display("mismatches %0d checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Read data watcher: valid only in the cycle after the strobe
   always @(posedge clk) rd_d <= rd;
   always @(negedge clk) begin
      if (rd_d === 1'b1) begin
         cmp32(rdata, expq.pop_front());
      end
   end
   initial begin
      repeat (4000) @(posedge clk);
      n_mismatch++;
      tally_and_finish();
   end
   initial begin
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      b = gdp_pkg::RST_FIRST;
      rd_chk(FR, b);
      rd_chk(gdp_pkg::OFS_SECOND, gdp_pkg::RST_SECOND);
      rd_chk(ST, 32'h0);
      rd_chk(8'h7F, 32'h0);
      repeat (4) begin
         v = rnd();
         wr_reg(FR, v);
         rd_chk(FR, v);
      end
      for (int i = 0; i < 4; i++) begin
         v = b | (32'(i) << 26) | 32'(3 - i) | (32'(i & 1) << 10);
         wr_reg(FR, v);
         repeat (2) @(negedge clk);
         cmp32(32'(analog), {27'h0, 2'(i), 2'(3 - i), 1'(i & 1)});
      end
      wr_reg(MK, 32'hF);
      // Overvoltage in report-only mode so the bridge stays with it
      wr_reg(FR, b ^ 32'h300);
      put(5'h03);
      see(1, 1'b0);
      wr_reg(FR, b ^ 32'h40300);
      see(1, 1'b1);
      cmp_bit(0, 1'b1);
      cmp_bit(3, 1'b1);
      rd_chk(ST, 32'h2);
      put(5'h01);
      see(1, 1'b0);
      wr_reg(FR, b ^ 32'hC0300);
      see(1, 1'b1);
      put(5'h00);
      see(1, 1'b0);
      rd_chk(ST, 32'h2);
      wr_reg(FR, b);
      put(5'h10);
      see(2, 1'b1);
      wr_reg(FR, b | 32'h10000);
      see(2, 1'b0);
      put(5'h00);
      see(2, 1'b1);
      rd_chk(ST, 32'h4);
      // Ignore, report only, level select, then latch
      wr_reg(FR, b | 32'h300);
      put(5'h04);
      see(2, 1'b1);
      wr_reg(FR, b ^ 32'h300);
      see(2, 1'b0);
      cmp_bit(0, 1'b0);
      wr_reg(FR, b ^ 32'h700);
      see(2, 1'b1);
      put(5'h0C);
      see(2, 1'b0);
      rd_chk(gdp_pkg::OFS_STATE, 32'h4);
      put(5'h00);
      wr_reg(FR, b & ~32'h300);
      put(5'h04);
      see(0, 1'b1);
      put(5'h00);
      see(0, 1'b1);
      cmp_bit(2, 1'b0);
      rd_chk(gdp_pkg::OFS_STATE, 32'h1);
      wr_reg(CT, 32'h2);
      see(0, 1'b0);
      cmp_bit(2, 1'b1);
      rd_chk(ST, 32'h1);
      retry_len(b, RS);
      retry_len(b | 32'h800, RL);
      rd_chk(ST, 32'h9);
      see(3, 1'b0);
      // Masked event holds off the interrupt until unmasked
      wr_reg(MK, 32'h0);
      wr_reg(FR, b ^ 32'h300);
      put(5'h04);
      see(3, 1'b0);
      put(5'h00);
      wr_reg(MK, 32'h1);
      see(3, 1'b1);
      rd_chk(ST, 32'h1);
      see(3, 1'b0);
      v = rnd();
      @(posedge clk);
      current_range <= v[1:0];
      wr_reg(CT, 32'h1);
      repeat (30) @(negedge clk);
      cmp32(32'(analog.sense_gain), {30'h0, ~v[1:0]});
      rd_chk(CT, 32'h1);
      wr_reg(CT, 32'h0);
      repeat (2) @(negedge clk);
      cmp32(32'(analog.sense_gain), 32'h0);
      tally_and_finish();
   end
endmodule
